//--- design/nand_status_id_pkg.sv
// Constants, modes and pin bundle for the NAND status, identification and reset logic
package nand_status_id_pkg;
    // Command codes seen on the byte port
    localparam logic [7:0] CMD_READ       = 8'h00;
    localparam logic [7:0] CMD_READ_CONF  = 8'h30;
    localparam logic [7:0] CMD_CB_READ    = 8'h35;
    localparam logic [7:0] CMD_CB_INPUT   = 8'h85;
    localparam logic [7:0] CMD_PROG_CONF  = 8'h10;
    localparam logic [7:0] CMD_ERASE_CONF = 8'hD0;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_EDC_STATUS = 8'h7B;
    localparam logic [7:0] CMD_ID         = 8'h90;
    localparam logic [7:0] CMD_RESET      = 8'hFF;
    localparam logic [7:0] ID_ADDR        = 8'h00;
    // Status register value after a reset command with write protect high
    localparam logic [7:0] STATUS_RESET   = 8'hC0;
    // Status byte field positions
    localparam int BIT_FAIL      = 0;
    localparam int BIT_EDC_ERR   = 1;
    localparam int BIT_EDC_VALID = 2;
    localparam int BIT_READY     = 6;
    localparam int BIT_NOT_WP    = 7;
    // Identification sequence length and source page sector count
    localparam int ID_BYTES = 5;
    localparam int SECTORS  = 4;
    // Timing: clock rate and internal operation times
    localparam int CLK_MHZ    = 125;
    localparam int T_RST_NS   = 5000;
    localparam int T_READ_NS  = 25000;
    localparam int T_PROG_NS  = 200000;
    localparam int T_ERASE_NS = 1500000;
    localparam int RST_CYC    = (T_RST_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC   = (T_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int PROG_CYC   = (T_PROG_NS * CLK_MHZ + 999) / 1000;
    localparam int ERASE_CYC  = (T_ERASE_NS * CLK_MHZ + 999) / 1000;
    localparam int BUSY_W     = 18;
    // Identification byte defaults; the values are arbitrary
    localparam logic [7:0] ID_MAKER_DEF = 8'h5A;
    localparam logic [7:0] ID_DEV_DEF   = 8'h3C;
    localparam logic [7:0] ID_B3_DEF    = 8'h11;
    localparam logic [7:0] ID_B4_DEF    = 8'h22;
    localparam logic [7:0] ID_B5_DEF    = 8'h33;

    // Command state of the device
    typedef enum logic [4:0] {
        MODE_WAIT   = 5'b00001,
        MODE_READ   = 5'b00010,
        MODE_STATUS = 5'b00100,
        MODE_EDC    = 5'b01000,
        MODE_ID     = 5'b10000
    } cmd_mode_e;

    // Host-side pins, all active low except cle, ale and io
    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       read_strobe_low;
        logic       wp_n;
        logic [7:0] io;
    } host_pins_s;
endpackage

//--- design/nand_status_id_reset_logic.sv
// Command decoder, status, identification, reset and ready/busy logic of a NAND device
//
// Contract
// - Error-detection status only after copy-back program
// - After 7Bh, read cycles drive error-detection status
// - Status shown live without re-toggling strobes
// - Error-detection status mode holds until next command
// - Bit 0: program pass zero, fail one
// - Bit 1: source page error detected
// - Bit 2: error report valid
// - Bit 6: busy zero, ready one
// - Bit 7: protected zero, unprotected one
// - Only single-bit error per sector detected
// - 90h plus address zero yields five bytes
// - Identification mode holds until next command
// - FFh resets, aborting operation in progress
// - Reset clears command state, status C0h
// - Reset accepted while already resetting
// - Ready/busy low for reset busy time
// - Power-up latches read setup; reset waits
// - Busy on program, erase, random read start
// - Ready/busy is open-drain, wired-OR capable
// - Plain status mode holds until next command
`timescale 1ns/10ps
module nand_status_id_reset_logic #(
    parameter logic [17:0] RST_CYC   = 18'(nand_status_id_pkg::RST_CYC),
    parameter logic [17:0] READ_CYC  = 18'(nand_status_id_pkg::READ_CYC),
    parameter logic [17:0] PROG_CYC  = 18'(nand_status_id_pkg::PROG_CYC),
    parameter logic [17:0] ERASE_CYC = 18'(nand_status_id_pkg::ERASE_CYC),
    parameter logic [7:0]  ID_MAKER  = nand_status_id_pkg::ID_MAKER_DEF,
    parameter logic [7:0]  ID_DEV    = nand_status_id_pkg::ID_DEV_DEF,
    parameter logic [7:0]  ID_B3     = nand_status_id_pkg::ID_B3_DEF,
    parameter logic [7:0]  ID_B4     = nand_status_id_pkg::ID_B4_DEF,
    parameter logic [7:0]  ID_B5     = nand_status_id_pkg::ID_B5_DEF
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire nand_status_id_pkg::host_pins_s         pins,
    input  wire logic                                   core_prog_fail,
    input  wire logic [nand_status_id_pkg::SECTORS-1:0] core_sector_err,
    input  wire logic                                   core_edc_valid,
    output logic [7:0]                                  io_out,
    output logic                                        io_oe,
    output logic                                        rb_oe
);
    // Width of the identification byte index
    localparam int               IDX_W    = $clog2(nand_status_id_pkg::ID_BYTES);
    // Last identification byte; the index stops there
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(nand_status_id_pkg::ID_BYTES - 1);
    // Number of source page sectors checked during copy-back
    localparam int               SEC      = nand_status_id_pkg::SECTORS;
    // Busy timer value that means no internal operation
    localparam logic [17:0]      CNT_IDLE = 18'h0_0000;
    // Busy timer value of the last busy cycle
    localparam logic [17:0]      CNT_ONE  = 18'h0_0001;

    // Strobe history for edge detection
    logic                          we_prev_r;     // Write strobe level last cycle, idles high
    logic                          rd_prev_r;     // Read cycle active last cycle, idles low
    // Command state
    nand_status_id_pkg::cmd_mode_e mode_r;        // Current command mode
    nand_status_id_pkg::cmd_mode_e mode_nxt;      // Mode after this cycle
    // Internal operation timer
    logic [17:0]                   busy_cnt_r;    // Cycles left of the internal operation
    logic [17:0]                   busy_cnt_nxt;  // Timer after this cycle
    logic                          busy;          // Internal operation running now
    logic                          busy_nxt;      // Internal operation running next cycle
    // Copy-back and program bookkeeping
    logic                          cb_src_r;      // Source page loaded for copy-back
    logic                          cb_src_nxt;    // Next value of the source flag
    logic                          edc_avail_r;   // Check bits belong to a copy-back
    logic                          edc_avail_nxt; // Next value of the check flag
    logic                          op_done_r;     // A program or erase has been started
    logic                          op_done_nxt;   // Next value of the started flag
    // Identification sequence
    logic                          id_armed_r;    // Address zero seen after the command
    logic                          id_armed_nxt;  // Next value of the armed flag
    logic [IDX_W-1:0]              id_idx_r;      // Next identification byte to show
    logic [IDX_W-1:0]              id_idx_nxt;    // Index after this cycle
    logic [7:0]                    id_rom [nand_status_id_pkg::ID_BYTES]; // Identification bytes
    // Byte port and ready/busy drivers
    logic [7:0]                    io_out_r;      // Byte shown on the port
    logic [7:0]                    io_out_nxt;    // Byte to show next cycle
    logic                          io_oe_r;       // Port driven by the device
    logic                          rb_oe_r;       // Ready/busy pulled low
    // Decoded strobes
    logic                          we_fall;       // Write strobe has just gone low
    logic                          cmd_stb;       // Command byte latched
    logic                          addr_stb;      // Address byte latched
    logic                          rd_act;        // Read cycle in progress
    logic                          rd_fall;       // Read cycle has just begun
    // Decoded commands
    logic                          cmd_reset;     // Reset command
    logic                          cmd_edc;       // Error-detection status command
    logic                          cmd_stat;      // Plain status command
    logic                          cmd_id;        // Identification command
    logic                          cmd_read;      // Read setup command
    logic                          cmd_rconf;     // Random read confirm
    logic                          cmd_cbread;    // Copy-back source read confirm
    logic                          cmd_cbin;      // Copy-back data input
    logic                          cmd_prog;      // Program confirm
    logic                          cmd_erase;     // Erase confirm
    logic                          addr_zero;     // Identification address of zero
    logic                          busy_start;    // Any command that starts the array
    logic                          in_status;     // Either status read mode
    // Status bytes
    logic [SEC-1:0]                sector_hit;    // Per-sector error flags of a copy-back
    logic [7:0]                    edc_byte;      // Error-detection status byte
    logic [7:0]                    stat_byte;     // Plain status byte

    // Strobe decode; pins are already synchronous to clk
    assign we_fall  = ~pins.ce_n & ~pins.we_n & we_prev_r;
    assign cmd_stb  = we_fall & pins.cle & ~pins.ale;
    assign addr_stb = we_fall & pins.ale & ~pins.cle;
    // A read cycle needs both selects low, so it starts on the later falling edge
    assign rd_act   = ~pins.ce_n & ~pins.read_strobe_low;
    assign rd_fall  = rd_act & ~rd_prev_r;

    // Busy now and in the next cycle
    assign busy     = busy_cnt_r != CNT_IDLE;
    assign busy_nxt = busy_cnt_nxt != CNT_IDLE;

    // Reset and both status commands are taken even while busy
    assign cmd_reset  = cmd_stb & (pins.io == nand_status_id_pkg::CMD_RESET);
    assign cmd_edc    = cmd_stb & (pins.io == nand_status_id_pkg::CMD_EDC_STATUS);
    assign cmd_stat   = cmd_stb & (pins.io == nand_status_id_pkg::CMD_STATUS);
    // Every other command is ignored while an internal operation runs
    assign cmd_id     = cmd_stb & ~busy & (pins.io == nand_status_id_pkg::CMD_ID);
    assign cmd_read   = cmd_stb & ~busy & (pins.io == nand_status_id_pkg::CMD_READ);
    assign cmd_rconf  = cmd_stb & ~busy & (pins.io == nand_status_id_pkg::CMD_READ_CONF);
    assign cmd_cbread = cmd_stb & ~busy & (pins.io == nand_status_id_pkg::CMD_CB_READ);
    assign cmd_cbin   = cmd_stb & ~busy & (pins.io == nand_status_id_pkg::CMD_CB_INPUT);
    assign cmd_prog   = cmd_stb & ~busy & (pins.io == nand_status_id_pkg::CMD_PROG_CONF);
    assign cmd_erase  = cmd_stb & ~busy & (pins.io == nand_status_id_pkg::CMD_ERASE_CONF);
    // Only a zero address after the identification command arms the sequence
    assign addr_zero  = addr_stb & (pins.io == nand_status_id_pkg::ID_ADDR)
                        & (mode_r == nand_status_id_pkg::MODE_ID);
    // Commands that pull ready/busy low
    assign busy_start = cmd_rconf | cmd_cbread | cmd_prog | cmd_erase;
    // Status modes, where the byte follows the live state
    assign in_status  = (mode_r == nand_status_id_pkg::MODE_EDC)
                        | (mode_r == nand_status_id_pkg::MODE_STATUS);

    // Identification bytes in read order
    assign id_rom[0] = ID_MAKER;
    assign id_rom[1] = ID_DEV;
    assign id_rom[2] = ID_B3;
    assign id_rom[3] = ID_B4;
    assign id_rom[4] = ID_B5;

    // One flag per sector; the check finds at most one flipped bit per sector
    for (genvar s = 0; s < SEC; s++) begin : g_sector
        assign sector_hit[s] = core_sector_err[s] & edc_avail_r;
    end

    // Error-detection status byte, built from live state
    always_comb begin
        edc_byte = 8'h00;
        edc_byte[nand_status_id_pkg::BIT_FAIL]      = core_prog_fail & op_done_r;
        edc_byte[nand_status_id_pkg::BIT_EDC_ERR]   = |sector_hit;
        edc_byte[nand_status_id_pkg::BIT_EDC_VALID] = core_edc_valid & edc_avail_r;
        edc_byte[nand_status_id_pkg::BIT_READY]     = ~busy_nxt;
        edc_byte[nand_status_id_pkg::BIT_NOT_WP]    = pins.wp_n;
    end
    // Plain status leaves the copy-back check bits at zero
    assign stat_byte = edc_byte & 8'hF9;

    // Internal operation timer; a reset aborts whatever runs and restarts it
    always_comb begin
        busy_cnt_nxt = busy ? busy_cnt_r - CNT_ONE : busy_cnt_r;
        if (cmd_reset) begin
            busy_cnt_nxt = RST_CYC;
        end else if (cmd_rconf | cmd_cbread) begin
            busy_cnt_nxt = READ_CYC;
        end else if (cmd_prog) begin
            busy_cnt_nxt = PROG_CYC;
        end else if (cmd_erase) begin
            busy_cnt_nxt = ERASE_CYC;
        end
    end

    // Command mode; a mode holds until the next accepted command
    always_comb begin
        mode_nxt = mode_r;
        if (cmd_reset) begin
            mode_nxt = nand_status_id_pkg::MODE_WAIT;
        end else if (cmd_edc) begin
            mode_nxt = nand_status_id_pkg::MODE_EDC;
        end else if (cmd_stat) begin
            mode_nxt = nand_status_id_pkg::MODE_STATUS;
        end else if (cmd_id) begin
            mode_nxt = nand_status_id_pkg::MODE_ID;
        end else if (cmd_read | cmd_rconf | cmd_cbread) begin
            mode_nxt = nand_status_id_pkg::MODE_READ;
        end else if (cmd_cbin | cmd_prog | cmd_erase) begin
            mode_nxt = nand_status_id_pkg::MODE_WAIT;
        end
    end

    // Copy-back source flag, consumed by the program confirm
    always_comb begin
        cb_src_nxt = cb_src_r;
        if (cmd_cbread) begin
            cb_src_nxt = 1'b1;
        end else if (cmd_reset | cmd_rconf | cmd_prog | cmd_erase) begin
            cb_src_nxt = 1'b0;
        end
    end

    // Check bits are offered only after a copy-back program
    always_comb begin
        edc_avail_nxt = edc_avail_r;
        if (cmd_prog) begin
            edc_avail_nxt = cb_src_r;
        end else if (cmd_reset | cmd_rconf | cmd_cbread | cmd_erase) begin
            edc_avail_nxt = 1'b0;
        end
    end

    // Pass/fail is reported once a program or erase has started; reset clears it
    always_comb begin
        op_done_nxt = op_done_r;
        if (cmd_prog | cmd_erase) begin
            op_done_nxt = 1'b1;
        end else if (cmd_reset) begin
            op_done_nxt = 1'b0;
        end
    end

    // Identification index; each read cycle moves to the next byte, up to the last
    always_comb begin
        id_armed_nxt = id_armed_r;
        id_idx_nxt   = id_idx_r;
        if (cmd_stb) begin
            id_armed_nxt = 1'b0;
            id_idx_nxt   = '0;
        end else if (addr_zero) begin
            id_armed_nxt = 1'b1;
            id_idx_nxt   = '0;
        end else if ((mode_r == nand_status_id_pkg::MODE_ID) && rd_fall && id_armed_r
                     && (id_idx_r < IDX_LAST)) begin
            id_idx_nxt   = id_idx_r + 1'b1;
        end
    end

    // Byte shown on the port in each mode
    always_comb begin
        io_out_nxt = io_out_r;
        case (mode_r)
            // Status is refreshed every cycle, no strobe toggle needed
            nand_status_id_pkg::MODE_EDC: begin
                if (rd_act) io_out_nxt = edc_byte;
            end
            nand_status_id_pkg::MODE_STATUS: begin
                if (rd_act) io_out_nxt = stat_byte;
            end
            // Identification byte taken at the start of each read cycle
            nand_status_id_pkg::MODE_ID: begin
                if (rd_fall && id_armed_r) io_out_nxt = id_rom[id_idx_r];
            end
            // Array data is not part of this block
            nand_status_id_pkg::MODE_READ: begin
                io_out_nxt = 8'h00;
            end
            nand_status_id_pkg::MODE_WAIT: begin
                io_out_nxt = 8'h00;
            end
            default: begin
                io_out_nxt = 8'h00;
            end
        endcase
    end

    // Strobe history; the write strobe idles high, the read cycle idles off
    always_ff @(posedge clk) begin
        if (rst) begin
            we_prev_r <= 1'b1;
            rd_prev_r <= 1'b0;
        end else begin
            we_prev_r <= pins.we_n;
            rd_prev_r <= rd_act;
        end
    end

    // Mode and timer; power-up behaves as if read setup were latched
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r     <= nand_status_id_pkg::MODE_READ;
            busy_cnt_r <= CNT_IDLE;
        end else begin
            mode_r     <= mode_nxt;
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    // Copy-back and identification bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            cb_src_r    <= 1'b0;
            edc_avail_r <= 1'b0;
            op_done_r   <= 1'b0;
            id_armed_r  <= 1'b0;
            id_idx_r    <= '0;
        end else begin
            cb_src_r    <= cb_src_nxt;
            edc_avail_r <= edc_avail_nxt;
            op_done_r   <= op_done_nxt;
            id_armed_r  <= id_armed_nxt;
            id_idx_r    <= id_idx_nxt;
        end
    end

    // Output flops; ready/busy only ever pulls low, so lines can be wired together
    always_ff @(posedge clk) begin
        if (rst) begin
            io_out_r <= 8'h00;
            io_oe_r  <= 1'b0;
            rb_oe_r  <= 1'b0;
        end else begin
            io_out_r <= io_out_nxt;
            io_oe_r  <= rd_act & (mode_r != nand_status_id_pkg::MODE_WAIT);
            rb_oe_r  <= busy_nxt;
        end
    end

    // Outputs straight from the flops
    assign io_out = io_out_r;
    assign io_oe  = io_oe_r;
    assign rb_oe  = rb_oe_r;

    // Checks of the command behaviour, all in the clk domain
    default clocking cb_main @(posedge clk); endclocking
    default disable iff (rst);

    // Reset command written
    sequence s_reset_cmd;
        cmd_reset;
    endsequence
    // Busy line low with a fresh reset timer
    sequence s_busy_on;
        rb_oe_r && (busy_cnt_r == RST_CYC);
    endsequence

    a_reset_busy_on: assert property (s_reset_cmd |=> s_busy_on)
        else $error("reset command did not start the busy time");
    a_reset_reload: assert property (s_reset_cmd and busy |=> s_busy_on)
        else $error("reset during busy did not restart the timer");
    a_reset_clears: assert property (s_reset_cmd |=> (mode_r == nand_status_id_pkg::MODE_WAIT)
        && !edc_avail_r && !op_done_r)
        else $error("reset did not clear the command state");
    a_rb_release: assert property ((busy_cnt_r == CNT_ONE) && !cmd_reset |=> !rb_oe_r)
        else $error("busy line held past the end of the operation");
    a_edc_mode_hold: assert property ((mode_r == nand_status_id_pkg::MODE_EDC) && !cmd_stb
        |=> (mode_r == nand_status_id_pkg::MODE_EDC))
        else $error("error-detection status mode left without a command");
    a_id_mode_hold: assert property ((mode_r == nand_status_id_pkg::MODE_ID) && !cmd_stb
        |=> (mode_r == nand_status_id_pkg::MODE_ID))
        else $error("identification mode left without a command");
    a_stat_mode_hold: assert property ((mode_r == nand_status_id_pkg::MODE_STATUS) && !cmd_stb
        |=> (mode_r == nand_status_id_pkg::MODE_STATUS))
        else $error("status mode left without a command");
    a_unused_zero: assert property (in_status && rd_act && !cmd_stb
        |=> (io_out_r[5:3] == 3'b000))
        else $error("unused status bits not zero");
    a_ready_bit: assert property (in_status && rd_act && !cmd_stb
        |=> (io_out_r[6] == !rb_oe_r))
        else $error("ready bit disagrees with the busy line");
    a_edc_gate: assert property (in_status && rd_act && !cmd_stb && !edc_avail_r
        |=> (io_out_r[2:1] == 2'b00))
        else $error("check bits shown without a copy-back");
endmodule

//--- verification/nand_host_model.sv
// Host controller model driving the NAND command and read strobes
`timescale 1ns/10ps
module nand_host_model (
    input  wire logic                          clk,
    input  wire logic [7:0]                    io,
    output nand_status_id_pkg::host_pins_s     pins
);
    // Idle: deselected, strobes high, write protect held low through power-up
    initial pins = 14'h2600;
    // Write protect level, changed only between cycles
    task automatic set_wp(input logic w);
        @(posedge clk) pins.wp_n <= w;
    endtask
    // Command or address write cycle, latch on the strobe low cycle
    task automatic wr(input logic c, input logic [7:0] d);
        @(posedge clk) pins <= '{1'b0, c, !c, 1'b0, 1'b1, pins.wp_n, d};
        @(posedge clk) pins.we_n <= 1'b1;
    endtask
    // Read cycle; strobe stays low so a live status can be watched
    task automatic rd(output logic [7:0] v);
        @(posedge clk) pins.read_strobe_low <= 1'b1;
        @(posedge clk) pins.read_strobe_low <= 1'b0;
        repeat (3) @(posedge clk);
        v = io;
    endtask
endmodule

//--- verification/tb_nand_status_id_reset_logic.sv
// Self-checking bench for status, identification and reset behaviour
`timescale 1ns/10ps
module tb_nand_status_id_reset_logic;
    // Power-up recovery of 100 us at the 8 ns clock
    localparam int         PWR_CYC = 12500;
    // Expected identification bytes in read order
    localparam logic [7:0] ID_EXP [5] = '{nand_status_id_pkg::ID_MAKER_DEF,
        nand_status_id_pkg::ID_DEV_DEF, nand_status_id_pkg::ID_B3_DEF,
        nand_status_id_pkg::ID_B4_DEF, nand_status_id_pkg::ID_B5_DEF};
    logic clk = 0, rst = 1, fail_r = 0, valid_r = 0, io_oe, rb_oe;
    logic [3:0] err = 0;
    logic [7:0] io_out, v;
    int         miscompares = 0, compares = 0, i;
    nand_status_id_pkg::host_pins_s pins;
    nand_host_model h_u (.clk(clk), .io(io_out), .pins(pins));
    nand_status_id_reset_logic #(.RST_CYC(18'h0008), .READ_CYC(18'h0010),
        .PROG_CYC(18'h0020), .ERASE_CYC(18'h0028)) dut_u (.clk(clk), .rst(rst),
        .pins(pins), .core_prog_fail(fail_r), .core_sector_err(err),
        .core_edc_valid(valid_r), .io_out(io_out), .io_oe(io_oe), .rb_oe(rb_oe));
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Expected copy-back status byte after a finished copy-back, unused bits zero
    function automatic logic [7:0] edc_exp();
        return {pins.wp_n, 1'b1, 3'b000, valid_r, |err, fail_r};
    endfunction
    // Wait until the busy line is released; first let the starting edge pass
    task automatic wait_ready;
        @(posedge clk);
        while (rb_oe) @(posedge clk);
    endtask
    // Plain status read expected at the reset value
    task automatic status_c0;
        h_u.wr(1, 8'h70);
        h_u.rd(v);
        chk(v, 8'hC0);
    endtask
    initial forever #4 clk = ~clk;
    initial begin #400000; miscompares++; finish_test; end
    initial begin
        i = $urandom(32'hf9a1);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (PWR_CYC) @(posedge clk);
        h_u.set_wp(1'b1);
        // Reset busy; a second reset while busy restarts the timer
        h_u.wr(1, 8'hFF);
        @(posedge clk) chk({7'h00, rb_oe}, 8'h01);
        h_u.wr(1, 8'hFF);
        repeat (7) @(posedge clk);
        chk({7'h00, rb_oe}, 8'h01);
        repeat (7) @(posedge clk);
        chk({7'h00, rb_oe}, 8'h00);
        status_c0;
        // Reset aborts a running program long before it would finish
        h_u.wr(1, 8'h10);
        h_u.wr(1, 8'hFF);
        repeat (10) @(posedge clk);
        chk({7'h00, rb_oe}, 8'h00);
        // Random read start pulls the busy line low
        h_u.wr(1, 8'h00);
        h_u.wr(1, 8'h30);
        @(posedge clk) chk({7'h00, rb_oe}, 8'h01);
        wait_ready;
        // Copy-back: source read, data input, program confirm
        h_u.wr(1, 8'h00);
        h_u.wr(1, 8'h35);
        wait_ready;
        h_u.wr(1, 8'h85);
        h_u.wr(1, 8'h10);
        @(posedge clk) chk({7'h00, rb_oe}, 8'h01);
        wait_ready;
        for (i = 0; i < 6; i++) begin
            @(posedge clk) {fail_r, valid_r, err} <= (i == 5) ? 6'h3F : 6'($urandom);
            h_u.wr(1, 8'h7B);
            h_u.rd(v);
            chk(v, edc_exp());
            chk(v & 8'hC7, edc_exp() & 8'hC7);
            chk({7'h00, io_oe}, 8'h01);
            chk({7'h00, v[0]}, {7'h00, fail_r});
            chk({7'h00, v[1]}, {7'h00, |err});
            chk({7'h00, v[2]}, {7'h00, valid_r});
            @(posedge clk) {fail_r, valid_r, err} <= ~{fail_r, valid_r, err};
            repeat (3) @(posedge clk);
            chk(io_out, edc_exp());
        end
        // Plain status hides the copy-back check bits
        h_u.wr(1, 8'h70);
        h_u.rd(v);
        chk(v, {pins.wp_n, 1'b1, 3'b000, 2'b00, fail_r});
        // Write protect shows in the top bit
        h_u.set_wp(1'b0);
        h_u.wr(1, 8'h7B);
        h_u.rd(v);
        chk(v, edc_exp());
        h_u.set_wp(1'b1);
        // Identification sequence
        h_u.wr(1, 8'h90);
        h_u.wr(0, 8'h00);
        for (i = 0; i < 5; i++) begin
            h_u.rd(v);
            chk(v, ID_EXP[i]);
        end
        // Reset in mid-run: busy line released, status back to its reset value
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) chk({7'h00, rb_oe}, 8'h00);
        status_c0;
        finish_test;
    end
endmodule
